// ===== hw/dpg_pkg.sv
// dpg_pkg: constants for the dual port gpio block
// assumes: avalon-mm register bus, 32-bit data, byte addressed words
package dpg_pkg;
    // ==========================================================
    // register indexes (byte address is four times the index)
    localparam logic [7:0] IDX_PB_IEN = 8'h0e;
    localparam logic [7:0] IDX_PA_DATA = 8'h10;
    localparam logic [7:0] IDX_PA_DIR = 8'h11;
    localparam logic [7:0] IDX_PA_PULL = 8'h12;
    localparam logic [7:0] IDX_PB_DATA = 8'h14;
    localparam logic [7:0] IDX_PB_DIR = 8'h15;
    localparam logic [7:0] IDX_PB_PULL = 8'h16;
    localparam logic [7:0] IDX_STATUS = 8'h18;
    localparam int ADDR_W = 10;
    // ==========================================================
    // reset values
    localparam logic [7:0] RST_PB_IEN = 8'hff;
    localparam logic [7:0] RST_DIR = 8'h00;
    localparam logic [7:0] RST_PULL = 8'h00;
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
    // ==========================================================
    // special pin positions
    localparam int PA_OD_PIN = 5;
    localparam int PB_INT0_PIN = 0;
    localparam int PB_INT7_PIN = 7;
    // bus slave states
    typedef enum logic [1:0] {DPG_IDLE, DPG_ACK, DPG_DONE} dpg_bus_st_t;
endpackage

// ===== hw/dpg_port.sv
// dpg_port: one 8-pin port, sync, pad drive, pull and read mux
// assumes: pin inputs are asynchronous; controls come from dpg_top
`timescale 1ns/1ps
module dpg_port #(
    parameter bit OD_EN = 1'b0,
    parameter int OD_PIN = 0
) (
    input wire logic core_clk,
    input wire logic rst_n,
    dpg_port_if.port p
);
    import dpg_pkg::*;
    logic [7:0] s1_r, s1_nxt, s2_r, s2_nxt;
    // ==========================================================
    // two flip-flop synchroniser next values
    always_comb begin
        s1_nxt = p.pin_in;
        s2_nxt = s1_r;
    end
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s1_r <= RST_DATA;
            s2_r <= RST_DATA;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
        end
    end
    // ==========================================================
    // per-pin drive, pull, digital input and read value
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_pin
            if (OD_EN && i == OD_PIN) begin : g_od
                // drive low only; data 1 leaves the pad tristated
                assign p.pin_oe_n[i] = ~(p.dir[i] & ~p.out_latch[i]);
                assign p.pin_out[i] = 1'b0;
                assign p.pull_on[i] = 1'b0;
            end else begin : g_pp
                assign p.pin_oe_n[i] = ~p.dir[i];
                assign p.pin_out[i] = p.out_latch[i];
                // pull acts only in input mode
                assign p.pull_on[i] = p.pull[i] & ~p.dir[i];
            end
            assign p.din_gated[i] = s2_r[i] & p.ien[i];
            // inputs read the pad, outputs read the latch
            assign p.rd_val[i] = p.dir[i] ? p.out_latch[i] : s2_r[i];
        end
    endgenerate
    assign p.pin_sync = s2_r;
endmodule

// ===== hw/dpg_port_if.sv
// dpg_port_if: control and sample bundle between top and a port slice
// assumes: one clock domain, driven by dpg_top
`timescale 1ns/1ps
interface dpg_port_if;
    logic [7:0] out_latch;
    logic [7:0] dir;
    logic [7:0] pull;
    logic [7:0] ien;
    logic [7:0] pin_sync;
    logic [7:0] pin_in;
    logic [7:0] pin_oe_n;
    logic [7:0] pin_out;
    logic [7:0] pull_on;
    logic [7:0] din_gated;
    logic [7:0] rd_val;
    modport ctl (output out_latch, dir, pull, ien, pin_in,
                 input pin_sync, pin_oe_n, pin_out, pull_on, din_gated,
                 rd_val);
    modport port (input out_latch, dir, pull, ien, pin_in,
                  output pin_sync, pin_oe_n, pin_out, pull_on, din_gated,
                  rd_val);
endinterface

// ===== hw/dpg_top.sv
// dpg_top: two 8-bit gpio ports behind an avalon-mm slave
// assumes: synchronous active-low reset, pins asynchronous to core_clk
//
// How it works
// - port b input-enable bits gate digital input and wake per pin.
// - pins b1..b6 with input disabled never raise wake.
// - pin b7 with input disabled raises neither interrupt nor wake.
// - pin b0 enable bit gates its input, interrupt and wake together.
// - port a data register at index 0x10, read and write.
// - port a direction at 0x11, 1 output, reset zero.
// - pin a5 drives low only; output with data 1 is tristate.
// - port a pull-high at 0x12 acts only in input mode, reset zero.
// - pin a5 pull-high bit has no effect.
// - port b data register at index 0x14, read and write.
// - port b direction at 0x15, 1 output, reset zero.
// - port b pull-high at 0x16 enables pull per pin in input mode only, reset zero.
`timescale 1ns/1ps
module dpg_top (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [dpg_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [7:0] port_a_pin_in,
    output logic [7:0] port_a_pin_out,
    output logic [7:0] port_a_pin_oe_n,
    output logic [7:0] port_a_pull_on,
    input wire logic [7:0] port_b_pin_in,
    output logic [7:0] port_b_pin_out,
    output logic [7:0] port_b_pin_oe_n,
    output logic [7:0] port_b_pull_on,
    output logic [7:0] port_b_din,
    output logic port_b_pin0_irq,
    output logic port_b_pin7_irq,
    output logic wake_req
);
    import dpg_pkg::*;
    dpg_port_if pa_if ();
    dpg_port_if pb_if ();

    logic [7:0] pa_data_r, pa_data_nxt, pa_dir_r, pa_dir_nxt;
    logic [7:0] pa_pull_r, pa_pull_nxt;
    logic [7:0] pb_data_r, pb_data_nxt, pb_dir_r, pb_dir_nxt;
    logic [7:0] pb_pull_r, pb_pull_nxt, pb_ien_r, pb_ien_nxt;
    dpg_bus_st_t st_r, st_nxt;
    logic [31:0] rd_r, rd_nxt;
    logic [7:0] idx;
    logic wr_go, lane0;
    logic [7:0] pb_prev_r, pb_prev_nxt;
    logic [7:0] pa_prev_r, pa_prev_nxt;
    logic [7:0] pb_tog;
    logic [7:0] pa_tog;
    logic irq0_nxt, irq7_nxt, wake_nxt;
    logic irq0_r, irq7_r, wake_r;
    logic [7:0] pa_out_r, pa_oe_r, pa_pu_r, pb_out_r, pb_oe_r, pb_pu_r;
    logic [7:0] pb_din_r;

    // ==========================================================
    // port slices: a carries the drive-low-only pin
    dpg_port #(.OD_EN(1'b1), .OD_PIN(PA_OD_PIN)) u_pa (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .p(pa_if.port)
    );
    dpg_port #(.OD_EN(1'b0), .OD_PIN(0)) u_pb (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .p(pb_if.port)
    );
    // controls into the slices
    always_comb begin
        pa_if.out_latch = pa_data_r;
        pa_if.dir = pa_dir_r;
        pa_if.pull = pa_pull_r;
        pa_if.ien = 8'hff;
        pa_if.pin_in = port_a_pin_in;
        pb_if.out_latch = pb_data_r;
        pb_if.dir = pb_dir_r;
        pb_if.pull = pb_pull_r;
        pb_if.ien = pb_ien_r;
        pb_if.pin_in = port_b_pin_in;
    end

    // ==========================================================
    // avalon slave: one wait cycle, read latched at the take edge, write at the ack edge
    assign idx = avs_address[ADDR_W-1:2];
    assign lane0 = avs_byteenable[0];
    always_comb begin
        st_nxt = st_r;
        rd_nxt = rd_r;
        wr_go = 1'b0;
        case (st_r)
            DPG_IDLE: begin
                if (avs_read || avs_write) begin
                    st_nxt = DPG_ACK;
                end
                // read data is latched on the take edge so that it
                // already stands while waitrequest is low
                if (avs_read) begin
                    rd_nxt = RD_UNMAPPED;
                    case (idx)
                        IDX_PA_DATA: rd_nxt[7:0] = pa_if.rd_val;
                        IDX_PA_DIR: rd_nxt[7:0] = pa_dir_r;
                        IDX_PA_PULL: rd_nxt[7:0] = pa_pull_r;
                        IDX_PB_DATA: rd_nxt[7:0] = pb_if.rd_val;
                        IDX_PB_DIR: rd_nxt[7:0] = pb_dir_r;
                        IDX_PB_PULL: rd_nxt[7:0] = pb_pull_r;
                        IDX_STATUS: rd_nxt[7:0] = pb_if.din_gated;
                        default: rd_nxt = RD_UNMAPPED;
                    endcase
                end
            end
            DPG_ACK: begin
                wr_go = avs_write;
                st_nxt = DPG_DONE;
            end
            DPG_DONE: st_nxt = DPG_IDLE;
            default: st_nxt = DPG_IDLE;
        endcase
    end
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_r <= DPG_IDLE;
            rd_r <= RD_UNMAPPED;
            avs_waitrequest <= 1'b1;
        end else begin
            st_r <= st_nxt;
            rd_r <= rd_nxt;
            avs_waitrequest <= ~(st_nxt == DPG_ACK);
        end
    end
    assign avs_readdata = rd_r;

    // ==========================================================
    // register writes, byte lane 0 only
    always_comb begin
        pa_data_nxt = pa_data_r;
        pa_dir_nxt = pa_dir_r;
        pa_pull_nxt = pa_pull_r;
        pb_data_nxt = pb_data_r;
        pb_dir_nxt = pb_dir_r;
        pb_pull_nxt = pb_pull_r;
        pb_ien_nxt = pb_ien_r;
        if (wr_go && lane0) begin
            case (idx)
                IDX_PB_IEN: pb_ien_nxt = avs_writedata[7:0];
                IDX_PA_DATA: pa_data_nxt = avs_writedata[7:0];
                IDX_PA_DIR: pa_dir_nxt = avs_writedata[7:0];
                IDX_PA_PULL: pa_pull_nxt = avs_writedata[7:0];
                IDX_PB_DATA: pb_data_nxt = avs_writedata[7:0];
                IDX_PB_DIR: pb_dir_nxt = avs_writedata[7:0];
                IDX_PB_PULL: pb_pull_nxt = avs_writedata[7:0];
                default: pb_ien_nxt = pb_ien_r;
            endcase
        end
    end
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pa_data_r <= RST_DATA;
            pa_dir_r <= RST_DIR;
            pa_pull_r <= RST_PULL;
            pb_data_r <= RST_DATA;
            pb_dir_r <= RST_DIR;
            pb_pull_r <= RST_PULL;
            pb_ien_r <= RST_PB_IEN;
        end else begin
            pa_data_r <= pa_data_nxt;
            pa_dir_r <= pa_dir_nxt;
            pa_pull_r <= pa_pull_nxt;
            pb_data_r <= pb_data_nxt;
            pb_dir_r <= pb_dir_nxt;
            pb_pull_r <= pb_pull_nxt;
            pb_ien_r <= pb_ien_nxt;
        end
    end

    // ==========================================================
    // toggle detect on gated inputs for wake and interrupt
    always_comb begin
        pb_prev_nxt = pb_if.din_gated;
        pa_prev_nxt = pa_if.pin_sync;
        pb_tog = pb_if.din_gated ^ pb_prev_r;
        pa_tog = pa_if.pin_sync ^ pa_prev_r;
        irq0_nxt = pb_tog[PB_INT0_PIN] & pb_ien_r[PB_INT0_PIN];
        irq7_nxt = pb_tog[PB_INT7_PIN] & pb_ien_r[PB_INT7_PIN];
        // disabled pins of port b cannot wake
        wake_nxt = |(pb_tog & pb_ien_r) | (|pa_tog);
    end
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pb_prev_r <= RST_DATA;
            pa_prev_r <= RST_DATA;
            irq0_r <= 1'b0;
            irq7_r <= 1'b0;
            wake_r <= 1'b0;
        end else begin
            pb_prev_r <= pb_prev_nxt;
            pa_prev_r <= pa_prev_nxt;
            irq0_r <= irq0_nxt;
            irq7_r <= irq7_nxt;
            wake_r <= wake_nxt;
        end
    end

    // ==========================================================
    // registered pad outputs
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pa_out_r <= 8'h00;
            pa_oe_r <= 8'hff;
            pa_pu_r <= 8'h00;
            pb_out_r <= 8'h00;
            pb_oe_r <= 8'hff;
            pb_pu_r <= 8'h00;
            pb_din_r <= 8'h00;
        end else begin
            pa_out_r <= pa_if.pin_out;
            pa_oe_r <= pa_if.pin_oe_n;
            pa_pu_r <= pa_if.pull_on;
            pb_out_r <= pb_if.pin_out;
            pb_oe_r <= pb_if.pin_oe_n;
            pb_pu_r <= pb_if.pull_on;
            pb_din_r <= pb_if.din_gated;
        end
    end
    assign port_a_pin_out = pa_out_r;
    assign port_a_pin_oe_n = pa_oe_r;
    assign port_a_pull_on = pa_pu_r;
    assign port_b_pin_out = pb_out_r;
    assign port_b_pin_oe_n = pb_oe_r;
    assign port_b_pull_on = pb_pu_r;
    assign port_b_din = pb_din_r;
    assign port_b_pin0_irq = irq0_r;
    assign port_b_pin7_irq = irq7_r;
    assign wake_req = wake_r;

    // ==========================================================
    // checks
    a_pa5_no_high: assert property (@(posedge core_clk) disable iff (!rst_n)
        !port_a_pin_oe_n[5] |-> !port_a_pin_out[5])
        else $error("pin a5 driven high");
    a_pa5_tristate: assert property (@(posedge core_clk) disable iff (!rst_n)
        (pa_dir_r[5] && pa_data_r[5]) |=> port_a_pin_oe_n[5])
        else $error("pin a5 not tristate on data one");
    a_pa5_no_pull: assert property (@(posedge core_clk) disable iff (!rst_n)
        !port_a_pull_on[5])
        else $error("pin a5 pull active");
    a_pa_pull_in: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(pa_dir_r[0]) |-> !port_a_pull_on[0])
        else $error("pull active in output mode");
    a_pb_pull_on: assert property (@(posedge core_clk) disable iff (!rst_n)
        (pb_pull_r[2] && !pb_dir_r[2]) |=> port_b_pull_on[2])
        else $error("port b pull missing");
    a_b0_irq_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
        !pb_ien_r[0] |=> !port_b_pin0_irq)
        else $error("pin b0 interrupt while disabled");
    a_b7_irq_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
        !pb_ien_r[7] |=> !port_b_pin7_irq)
        else $error("pin b7 interrupt while disabled");
    a_pb_din_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
        !pb_ien_r[3] |=> !port_b_din[3])
        else $error("disabled input seen");
    a_pb_dir_out: assert property (@(posedge core_clk) disable iff (!rst_n)
        pb_dir_r[1] |=> (!port_b_pin_oe_n[1]
            && port_b_pin_out[1] == $past(pb_data_r[1])))
        else $error("port b output not driven");
    a_ack_one: assert property (@(posedge core_clk) disable iff (!rst_n)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low two cycles");
    a_rd_upper_zero: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    // input mode releases the pad, pull follows input mode
    a_pa_dir_in: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !pa_dir_r[0] |=> port_a_pin_oe_n[0])
        else $error("port a input pin driven");
    a_pb_dir_in: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !pb_dir_r[6] |=> port_b_pin_oe_n[6])
        else $error("port b input pin driven");
    a_pa_pull_on: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (pa_pull_r[0] && !pa_dir_r[0]) |=> port_a_pull_on[0])
        else $error("port a pull missing");
    // enabled inputs pass, disabled inputs stay quiet
    a_pb_din_pass: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        pb_ien_r[4] |=> port_b_din[4] == $past(pb_if.pin_sync[4]))
        else $error("enabled input not passed");
    a_wake_gate: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (pb_ien_r == 8'h00 && pa_tog == 8'h00) |=> !wake_req)
        else $error("wake from disabled pins");
    a_b0_irq_edge: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (pb_ien_r[0] && $past(pb_ien_r[0])
            && pb_if.pin_sync[0] != $past(pb_if.pin_sync[0]))
            |=> port_b_pin0_irq)
        else $error("pin b0 edge without interrupt");
    a_b7_irq_edge: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (pb_ien_r[7] && $past(pb_ien_r[7])
            && pb_if.pin_sync[7] != $past(pb_if.pin_sync[7]))
            |=> port_b_pin7_irq)
        else $error("pin b7 edge without interrupt");
endmodule

// ===== tb/dpg_pins_model.sv
// dpg_pins_model: external pads seen from the far side of one gpio port
// assumes: bench sets the outside driver; one core_clk domain
`timescale 1ns/1ps
module dpg_pins_model (
    input wire logic core_clk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] pull_on,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_in
);
    logic [7:0] last_r = 8'h00;
    // ==========================================================
    // pad level: core drive, then outside drive, then pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_val[i];
            end else if (pull_on[i]) begin
                pin_in[i] = 1'b1;
            end else begin
                pin_in[i] = ~last_r[i]; // floating pad wanders
            end
        end
    end
    // remember the level so a floating pad keeps moving
    always_ff @(posedge core_clk) begin
        last_r <= pin_in;
    end
endmodule

// ===== tb/test_dpg_top.sv
// test_dpg_top: register and pad checks of the dual port gpio block
// assumes: dpg_top avalon-mm slave, word index in address bits 9:2
`timescale 1ns/1ps
module test_dpg_top;
    import dpg_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [7:0] pa_in, pa_out, pa_oe_n, pa_pull, pb_in, pb_out, pb_oe_n;
    logic [7:0] pb_pull, port_b_din;
    logic port_b_pin0_irq, port_b_pin7_irq, wake_req;
    logic [7:0] ext_en_a = 8'h00;
    logic [7:0] ext_val_a = 8'h00;
    logic [7:0] ext_en_b = 8'h00;
    logic [7:0] ext_val_b = 8'h00;
    logic [7:0] idx_tab [4] = '{IDX_PA_DIR, IDX_PA_PULL, IDX_PB_DIR,
                                IDX_PB_PULL};
    logic [31:0] rd;
    int fail_count = 0;
    int num_checks = 0;
    int w, i0, i7;
    // ==========================================================
    // clock, design and pads
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    dpg_top dut (.core_clk(core_clk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .port_a_pin_in(pa_in),
        .port_a_pin_out(pa_out), .port_a_pin_oe_n(pa_oe_n),
        .port_a_pull_on(pa_pull), .port_b_pin_in(pb_in),
        .port_b_pin_out(pb_out), .port_b_pin_oe_n(pb_oe_n),
        .port_b_pull_on(pb_pull), .port_b_din(port_b_din),
        .port_b_pin0_irq(port_b_pin0_irq),
        .port_b_pin7_irq(port_b_pin7_irq), .wake_req(wake_req));
    dpg_pins_model pins_a (.core_clk(core_clk), .pin_out(pa_out),
        .pin_oe_n(pa_oe_n), .pull_on(pa_pull), .ext_en(ext_en_a),
        .ext_val(ext_val_a), .pin_in(pa_in));
    dpg_pins_model pins_b (.core_clk(core_clk), .pin_out(pb_out),
        .pin_oe_n(pb_oe_n), .pull_on(pb_pull), .ext_en(ext_en_b),
        .ext_val(ext_val_b), .pin_in(pb_in));
    // ==========================================================
    // compare, verdict and bus tasks
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task results;
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // one avalon cycle, held until waitrequest is sampled low
    task bus(input bit wr, input logic [7:0] idx, input logic [7:0] wd,
             input logic [3:0] be);
        int n;
        @(posedge core_clk);
        avs_address <= {idx, 2'b00};
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h00_0000, wd};
        avs_byteenable <= be;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) begin
            fail_count++;
            $display("ERROR t=%0t bus answer missing", $time);
            results();
        end else begin
            rd = avs_readdata;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
        end
    endtask
    task wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, 4'hf);
    endtask
    task rdchk(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00, 4'hf);
        chk(rd, {24'h00_0000, exp});
    endtask
    // count pulses seen over n edges
    task watch(input int n);
        w = 0;
        i0 = 0;
        i7 = 0;
        repeat (n) begin
            @(posedge core_clk);
            w += (wake_req === 1'b1);
            i0 += (port_b_pin0_irq === 1'b1);
            i7 += (port_b_pin7_irq === 1'b1);
        end
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        chk(pa_oe_n, 8'hff);
        chk(pb_pull, 8'h00);
        for (int i = 0; i < 4; i++) begin
            rdchk(idx_tab[i], 8'h00);
            wr(idx_tab[i], 8'ha5);
            rdchk(idx_tab[i], 8'ha5);
            wr(idx_tab[i], 8'h00);
        end
        rdchk(IDX_PB_IEN, 8'h00);
        rdchk(8'h30, 8'h00);
        bus(1'b1, IDX_PA_DIR, 8'hff, 4'h0);
        rdchk(IDX_PA_DIR, 8'h00);
        // port a outputs, pin 5 low-only
        wr(IDX_PA_DATA, 8'hff);
        wr(IDX_PA_DIR, 8'hff);
        repeat (2) @(posedge core_clk);
        chk(pa_oe_n, 8'h20);
        chk(pa_out, 8'hdf);
        rdchk(IDX_PA_DATA, 8'hff);
        wr(IDX_PA_DATA, 8'h00);
        repeat (2) @(posedge core_clk);
        chk(pa_oe_n, 8'h00);
        // port a inputs, mixed direction read, pull-ups
        ext_en_a <= 8'hff;
        ext_val_a <= 8'h3c;
        wr(IDX_PA_DIR, 8'h00);
        repeat (4) @(posedge core_clk);
        rdchk(IDX_PA_DATA, 8'h3c);
        wr(IDX_PA_DIR, 8'h0f);
        rdchk(IDX_PA_DATA, 8'h30);
        wr(IDX_PA_PULL, 8'hff);
        repeat (2) @(posedge core_clk);
        chk(pa_pull, 8'hd0);
        wr(IDX_PA_DIR, 8'h00);
        repeat (2) @(posedge core_clk);
        chk(pa_pull, 8'hdf);
        // port b outputs and pull-ups
        wr(IDX_PB_DATA, 8'h96);
        wr(IDX_PB_DIR, 8'hff);
        repeat (2) @(posedge core_clk);
        chk(pb_out, 8'h96);
        chk(pb_oe_n, 8'h00);
        rdchk(IDX_PB_DATA, 8'h96);
        ext_en_b <= 8'hff;
        wr(IDX_PB_DIR, 8'h00);
        wr(IDX_PB_PULL, 8'h5a);
        repeat (2) @(posedge core_clk);
        chk(pb_pull, 8'h5a);
        // inputs disabled as for analog use: no din, irq or wake
        wr(IDX_PB_IEN, 8'h00);
        for (int k = 0; k < 8; k++) begin
            ext_val_b <= ext_val_b ^ (8'h01 << k);
            watch(8);
            chk({port_b_din, 8'(w), 8'(i0), 8'(i7)}, 32'h0);
        end
        // inputs enabled: every toggle wakes, b0 and b7 interrupt
        wr(IDX_PB_IEN, 8'hff);
        watch(8);
        chk(port_b_din, 8'hff);
        rdchk(IDX_STATUS, 8'hff);
        for (int k = 0; k < 8; k++) begin
            ext_val_b <= ext_val_b ^ (8'h01 << k);
            watch(8);
            chk({8'(w), 8'(i0), 8'(i7)}, {8'd1, 8'(k == 0), 8'(k == 7)});
            chk(port_b_din, 8'(8'hff << (k + 1)));
        end
        rdchk(IDX_STATUS, 8'h00);
        results();
    end
endmodule
